// [core/pitc_controller.sv]
`timescale 1ns/100ps
module pitc_controller #(
	parameter int NUM_SOURCES = pitc_pkg::NUM_SOURCES,
	parameter int TIMED_INTERRUPT_BLOCK_CNT_W  = pitc_pkg::TIMED_INTERRUPT_BLOCK_CNT_W
) (
	// Clock and reset
	input  wire logic                               clk,
	input  wire logic                               srst,
	// Peripheral requests and software flag control
	input  wire logic [NUM_SOURCES-1:0]             irq_request,
	input  wire logic [NUM_SOURCES-1:0]             irq_flag_set,
	input  wire logic [NUM_SOURCES-1:0]             irq_flag_clear,
	input  wire logic [NUM_SOURCES-1:0]             irq_enable,
	input  wire logic [NUM_SOURCES*3-1:0]           irq_priority,
	// Trap conditions
	input  wire logic                               clock_failure_monitor,
	input  wire logic                               misaligned_access,
	input  wire logic                               stack_error,
	input  wire logic                               accumulator_overflow,
	input  wire logic                               math_trap_enable,
	input  wire logic [pitc_pkg::NUM_TRAPS-1:0]     trap_flag_clear,
	// Control bits
	input  wire logic                               nesting_disable,
	input  wire logic                               alternate_table_select,
	input  wire logic                               level_write,
	input  wire logic [pitc_pkg::PRI_W-1:0]         level_write_data,
	// Core side
	input  wire logic                               instr_boundary,
	input  wire logic                               exception_taken,
	input  wire logic                               return_from_handler,
	input  wire logic                               timed_interrupt_block,
	input  wire logic [TIMED_INTERRUPT_BLOCK_CNT_W-1:0]              block_cycles,
	// Outputs
	output logic                                    exception_request,
	output logic [pitc_pkg::VEC_W-1:0]              exception_vector,
	output logic [pitc_pkg::ADDR_W-1:0]             vector_address,
	output logic [3:0]                              core_priority_level,
	output logic                                    block_active,
	output logic [NUM_SOURCES-1:0]                  irq_pending,
	output logic [pitc_pkg::NUM_TRAPS-1:0]          trap_pending,
	output logic                                    select_fast_rc,
	output logic                                    abort_access
);
	// ****************************************
	// Source slots
	// ****************************************
	logic [NUM_SOURCES-1:0]       slot_pending;
	logic [NUM_SOURCES-1:0]       slot_eligible;
	logic [NUM_SOURCES-1:0]       slot_ack;
	logic [pitc_pkg::PRI_W-1:0]   threshold;
	logic [pitc_pkg::PRI_W-1:0]   core_low;

	assign core_low = core_priority_level[pitc_pkg::PRI_W-1:0];

	always_comb begin
		// Traps raise the core above seven; nothing maskable gets through
		if (core_priority_level[3])
			threshold = pitc_pkg::PRI_MAX;
		else if (block_active && core_low < pitc_pkg::PRI_TIMED_INTERRUPT_BLOCK_LIMIT)
			threshold = pitc_pkg::PRI_TIMED_INTERRUPT_BLOCK_LIMIT;
		else
			threshold = core_low;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_slot
			pitc_src_slot u_slot (
				.clk            (clk),
				.srst           (srst),
				.request        (irq_request[gi]),
				.sw_set         (irq_flag_set[gi]),
				.sw_clear       (irq_flag_clear[gi]),
				.ack            (slot_ack[gi]),
				.enable         (irq_enable[gi]),
				.priority_level (irq_priority[gi*3 +: 3]),
				.threshold      (threshold),
				.pending        (slot_pending[gi]),
				.eligible       (slot_eligible[gi])
			);
		end
	endgenerate

	// ****************************************
	// Interrupt arbitration
	// ****************************************
	logic                         irq_found;
	logic [5:0]                   irq_index;
	logic [pitc_pkg::PRI_W-1:0]   irq_best;

	always_comb begin
		irq_found = 1'b0;
		irq_index = 6'h00;
		irq_best  = pitc_pkg::PRI_NEVER;
		// Strictly greater keeps the lowest index on a tie
		for (int i = 0; i < NUM_SOURCES; i++) begin
			if (slot_eligible[i] && (!irq_found || irq_priority[i*3 +: 3] > irq_best)) begin
				irq_found = 1'b1;
				irq_index = 6'(i);
				irq_best  = irq_priority[i*3 +: 3];
			end
		end
	end

	// ****************************************
	// Trap flags, fixed order
	// ****************************************
	logic [pitc_pkg::NUM_TRAPS-1:0] trap_cause;
	logic [pitc_pkg::NUM_TRAPS-1:0] trap_ack;
	logic [pitc_pkg::NUM_TRAPS-1:0] next_trap_pending;

	assign trap_cause = {accumulator_overflow && math_trap_enable,
	                     stack_error,
	                     misaligned_access,
	                     clock_failure_monitor};

	always_comb begin
		// Set wins over clear
		next_trap_pending = (trap_pending & ~(trap_flag_clear | trap_ack)) | trap_cause;
	end

	logic                         trap_found;
	logic [pitc_pkg::VEC_W-1:0]   trap_vec;
	logic [1:0]                   trap_index;

	always_comb begin
		trap_found = 1'b0;
		trap_index = 2'h0;
		trap_vec   = pitc_pkg::TRAP_OSC_VECTOR;
		if (trap_pending[0]) begin
			trap_found = 1'b1;
			trap_index = 2'h0;
			trap_vec   = pitc_pkg::TRAP_OSC_VECTOR;
		end else if (trap_pending[1]) begin
			trap_found = 1'b1;
			trap_index = 2'h1;
			trap_vec   = pitc_pkg::TRAP_ADDR_VECTOR;
		end else if (trap_pending[2]) begin
			trap_found = 1'b1;
			trap_index = 2'h2;
			trap_vec   = pitc_pkg::TRAP_STACK_VECTOR;
		end else if (trap_pending[3]) begin
			trap_found = 1'b1;
			trap_index = 2'h3;
			trap_vec   = pitc_pkg::TRAP_MATH_VECTOR;
		end
	end

	// ****************************************
	// Offer and fetch sequence
	// ****************************************
	pitc_pkg::pitc_state_type       state;
	pitc_pkg::pitc_state_type       next_state;
	logic                           next_request;
	logic [pitc_pkg::VEC_W-1:0]     next_vector;
	logic [pitc_pkg::ADDR_W-1:0]    next_address;
	logic                           offer_is_trap;
	logic                           next_offer_is_trap;
	logic [5:0]                     offer_index;
	logic [5:0]                     next_offer_index;
	logic [pitc_pkg::PRI_W-1:0]     offer_level;
	logic [pitc_pkg::PRI_W-1:0]     next_offer_level;
	logic [pitc_pkg::VEC_W-1:0]     cand_vector;
	logic [pitc_pkg::ADDR_W-1:0]    cand_base;
	logic [pitc_pkg::ADDR_W-1:0]    cand_address;

	always_comb begin
		// Traps outrank every maskable source
		if (trap_found)
			cand_vector = trap_vec;
		else
			cand_vector = pitc_pkg::VEC_W'(irq_index + pitc_pkg::FIRST_IRQ_VECTOR);
		if (alternate_table_select)
			cand_base = pitc_pkg::ALTERNATE_TABLE_BASE;
		else
			cand_base = pitc_pkg::PRIMARY_TABLE_BASE;
		// Entries are two addresses apart
		cand_address = cand_base + pitc_pkg::ADDR_W'({cand_vector, 1'b0});
	end

	always_comb begin
		next_state         = state;
		next_request       = exception_request;
		next_vector        = exception_vector;
		next_address       = vector_address;
		next_offer_is_trap = offer_is_trap;
		next_offer_index   = offer_index;
		next_offer_level   = offer_level;
		slot_ack           = '0;
		trap_ack           = '0;
		case (state)
			pitc_pkg::PITC_IDLE: begin
				// Only offered at an instruction boundary
				if (instr_boundary && (trap_found || irq_found)) begin
					next_state         = pitc_pkg::PITC_OFFER;
					next_request       = 1'b1;
					next_vector        = cand_vector;
					next_address       = cand_address;
					next_offer_is_trap = trap_found;
					next_offer_index   = trap_found ? {4'h0, trap_index} : irq_index;
					next_offer_level   = irq_best;
				end
			end
			pitc_pkg::PITC_OFFER: begin
				if (exception_taken) begin
					next_state   = pitc_pkg::PITC_FETCH;
					next_request = 1'b0;
					if (offer_is_trap)
						trap_ack[offer_index[1:0]] = 1'b1;
					else
						slot_ack[offer_index] = 1'b1;
				end else if (instr_boundary) begin
					// Re-evaluate so a newer winner replaces a stale offer
					next_state   = pitc_pkg::PITC_IDLE;
					next_request = 1'b0;
				end
			end
			pitc_pkg::PITC_FETCH: begin
				next_state = pitc_pkg::PITC_IDLE;
			end
			default: begin
				next_state   = pitc_pkg::PITC_IDLE;
				next_request = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Core priority level and timed block
	// ****************************************
	logic [3:0]               level_stack [0:15];
	logic [3:0]               next_level;
	logic [3:0]               depth;
	logic [3:0]               next_depth;
	logic [TIMED_INTERRUPT_BLOCK_CNT_W-1:0]    block_count;
	logic [TIMED_INTERRUPT_BLOCK_CNT_W-1:0]    next_block_count;
	logic                     push;

	assign push = (state == pitc_pkg::PITC_OFFER) && exception_taken;

	always_comb begin
		next_level = core_priority_level;
		next_depth = depth;
		if (push) begin
			next_depth = depth + 4'h1;
			if (offer_is_trap)
				next_level = pitc_pkg::TRAP_CPU_LEVEL;
			else if (nesting_disable)
				next_level = {1'b0, pitc_pkg::PRI_MAX};
			else
				next_level = {1'b0, offer_level};
		end else if (return_from_handler && depth != 4'h0) begin
			next_depth = depth - 4'h1;
			next_level = level_stack[next_depth];
		end else if (level_write && !nesting_disable && !core_priority_level[3]) begin
			next_level = {1'b0, level_write_data};
		end
		next_block_count = block_count;
		if (timed_interrupt_block)
			next_block_count = block_cycles;
		else if (block_count != '0 && instr_boundary)
			next_block_count = block_count - TIMED_INTERRUPT_BLOCK_CNT_W'(1);
	end

	always_ff @(posedge clk) begin
		if (push)
			level_stack[depth] <= core_priority_level;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state               <= pitc_pkg::PITC_IDLE;
			exception_request   <= 1'b0;
			exception_vector    <= '0;
			vector_address      <= '0;
			offer_is_trap       <= 1'b0;
			offer_index         <= '0;
			offer_level         <= '0;
			trap_pending        <= '0;
			core_priority_level <= '0;
			depth               <= '0;
			block_count         <= '0;
			block_active        <= 1'b0;
			irq_pending         <= '0;
			select_fast_rc      <= 1'b0;
			abort_access        <= 1'b0;
		end else begin
			state               <= next_state;
			exception_request   <= next_request;
			exception_vector    <= next_vector;
			vector_address      <= next_address;
			offer_is_trap       <= next_offer_is_trap;
			offer_index         <= next_offer_index;
			offer_level         <= next_offer_level;
			trap_pending        <= next_trap_pending;
			core_priority_level <= next_level;
			depth               <= next_depth;
			block_count         <= next_block_count;
			block_active        <= next_block_count != '0;
			irq_pending         <= slot_pending;
			select_fast_rc      <= select_fast_rc | clock_failure_monitor;
			abort_access        <= misaligned_access;
		end
	end
endmodule : pitc_controller

// [core/pitc_pkg.sv]
package pitc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_SOURCES     = 45;
	localparam int NUM_TRAPS       = 4;
	localparam int VEC_W           = 6;
	localparam int PRI_W           = 3;
	localparam int ADDR_W          = 24;
	localparam int TIMED_INTERRUPT_BLOCK_CNT_W      = 14;

	// ****************************************
	// Vector table layout (word addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] PRIMARY_TABLE_BASE   = 24'h00_0004;
	localparam logic [ADDR_W-1:0] ALTERNATE_TABLE_BASE = 24'h00_0084;
	localparam logic [ADDR_W-1:0] PRIMARY_IRQ_BASE     = 24'h00_0014;
	localparam logic [ADDR_W-1:0] ALTERNATE_IRQ_BASE   = 24'h00_0094;
	localparam logic [VEC_W-1:0]  FIRST_IRQ_VECTOR     = 6'h08;
	localparam logic [VEC_W-1:0]  TRAP_OSC_VECTOR      = 6'h01;
	localparam logic [VEC_W-1:0]  TRAP_ADDR_VECTOR     = 6'h02;
	localparam logic [VEC_W-1:0]  TRAP_STACK_VECTOR    = 6'h03;
	localparam logic [VEC_W-1:0]  TRAP_MATH_VECTOR     = 6'h04;

	// ****************************************
	// Priority levels
	// ****************************************
	localparam logic [PRI_W-1:0] PRI_NEVER      = 3'h0;
	localparam logic [PRI_W-1:0] PRI_MAX        = 3'h7;
	localparam logic [PRI_W-1:0] PRI_TIMED_INTERRUPT_BLOCK_LIMIT = 3'h6;
	localparam logic [3:0]       TRAP_CPU_LEVEL = 4'h8;

	typedef enum logic [1:0] {
		PITC_IDLE  = 2'b00,
		PITC_OFFER = 2'b01,
		PITC_FETCH = 2'b11
	} pitc_state_type;

endpackage : pitc_pkg

// [core/pitc_src_slot.sv]
`timescale 1ns/100ps
// ****************************************
// One interrupt source: pending flag and eligibility
// ****************************************
module pitc_src_slot (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         srst,
	// Source side
	input  wire logic                         request,
	input  wire logic                         sw_set,
	input  wire logic                         sw_clear,
	input  wire logic                         ack,
	// Configuration
	input  wire logic                         enable,
	input  wire logic [pitc_pkg::PRI_W-1:0]   priority_level,
	input  wire logic [pitc_pkg::PRI_W-1:0]   threshold,
	// Result
	output logic                              pending,
	output logic                              eligible
);
	logic next_pending;

	always_comb begin
		// Set wins over clear; software set acts like a hardware request
		next_pending = pending;
		if (sw_clear || ack)
			next_pending = 1'b0;
		if (request || sw_set)
			next_pending = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (srst)
			pending <= 1'b0;
		else
			pending <= next_pending;
	end

	// Enabled, pending, nonzero priority and above the threshold (current level, raised to six during a timed block)
	assign eligible = pending && enable && (priority_level != pitc_pkg::PRI_NEVER)
		&& (priority_level > threshold);
endmodule : pitc_src_slot

// [dv/pitc_core_model.sv]
`timescale 1ns/100ps
// ****************************************
// Core side: instruction boundaries and vector fetch
// ****************************************
module pitc_core_model (
	// Clock
	input  wire logic clk,
	// Controller side
	input  wire logic exception_request,
	input  wire logic slow,
	output logic      instr_boundary,
	output logic      exception_taken
);
	logic phase = 1'b0;
	always_ff @(posedge clk) begin
		phase <= ~phase;
	end
	// A slow core finishes an instruction only every other cycle
	assign instr_boundary  = ~slow | phase;
	// Offer is taken at a boundary and the handler word fetched
	assign exception_taken = exception_request & instr_boundary;
endmodule : pitc_core_model

// [dv/pitc_controller_sva.sv]
`timescale 1ns/100ps
module pitc_controller_sva #(
	parameter int NUM_SOURCES = 45,
	parameter int TIMED_INTERRUPT_BLOCK_CNT_W  = 14
) (
	input wire logic                         clk,
	input wire logic                         srst,
	input wire logic [NUM_SOURCES-1:0]       irq_enable,
	input wire logic [NUM_SOURCES*3-1:0]     irq_priority,
	input wire logic                         clock_failure_monitor,
	input wire logic                         misaligned_access,
	input wire logic                         nesting_disable,
	input wire logic                         alternate_table_select,
	input wire logic                         level_write,
	input wire logic                         exception_taken,
	input wire logic                         return_from_handler,
	input wire logic                         exception_request,
	input wire logic [pitc_pkg::VEC_W-1:0]   exception_vector,
	input wire logic [pitc_pkg::ADDR_W-1:0]  vector_address,
	input wire logic [3:0]                   core_priority_level,
	input wire logic                         block_active,
	input wire logic [pitc_pkg::NUM_TRAPS-1:0] trap_pending,
	input wire logic                         select_fast_rc,
	input wire logic                         abort_access
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic [2:0] sel_pri;
	logic       sel_en;
	logic       is_irq;
	int         idx;
	assign is_irq = exception_vector >= pitc_pkg::FIRST_IRQ_VECTOR;
	always_comb begin
		idx     = int'(exception_vector) - 8;
		sel_pri = 3'h0;
		sel_en  = 1'b0;
		if (idx >= 0 && idx < NUM_SOURCES) begin
			sel_pri = irq_priority[idx*3 +: 3];
			sel_en  = irq_enable[idx];
		end
	end
	chk_vec_address: assert property (exception_request |->
		vector_address == (alternate_table_select ? pitc_pkg::ALTERNATE_TABLE_BASE : pitc_pkg::PRIMARY_TABLE_BASE)
		+ {17'h0_0000, exception_vector, 1'b0})
		else $error("vector address off");
	chk_irq_eligible: assert property (exception_request && is_irq |->
		sel_en && {1'b0, sel_pri} > core_priority_level)
		else $error("ineligible source offered");
	chk_block_masks: assert property (exception_request && is_irq && block_active |-> sel_pri == 3'h7)
		else $error("blocked level offered");
	chk_entry_level: assert property (exception_request && exception_taken && is_irq |=>
		core_priority_level == ($past(nesting_disable) ? 4'h7 : {1'b0, $past(sel_pri)}))
		else $error("entry level wrong");
	chk_trap_level: assert property (exception_request && exception_taken && !is_irq |=>
		core_priority_level == pitc_pkg::TRAP_CPU_LEVEL) else $error("trap level wrong");
	chk_osc_first: assert property ($rose(exception_request) && $past(trap_pending[0]) |->
		exception_vector == pitc_pkg::TRAP_OSC_VECTOR) else $error("oscillator trap not first");
	chk_taken_drop: assert property (exception_request && exception_taken |=> !exception_request [*2])
		else $error("offer not withdrawn");
	chk_level_locked: assert property (nesting_disable && level_write && !exception_taken
		&& !return_from_handler |=> $stable(core_priority_level)) else $error("level written while locked");
	chk_fast_rc: assert property (clock_failure_monitor || select_fast_rc |=> select_fast_rc)
		else $error("fast rc not held");
	chk_abort_next: assert property (misaligned_access |=> abort_access) else $error("access not aborted");
	cov_irq_taken: cover property (exception_request && exception_taken && is_irq);
	cov_trap_taken: cover property (exception_request && exception_taken && !is_irq);
	cov_block: cover property (block_active && exception_request);
endmodule : pitc_controller_sva
bind pitc_controller pitc_controller_sva #(.NUM_SOURCES(NUM_SOURCES), .TIMED_INTERRUPT_BLOCK_CNT_W(TIMED_INTERRUPT_BLOCK_CNT_W)) u_pitc_controller_sva (
	.clk, .srst, .irq_enable, .irq_priority, .clock_failure_monitor, .misaligned_access, .nesting_disable,
	.alternate_table_select, .level_write, .exception_taken, .return_from_handler, .exception_request,
	.exception_vector, .vector_address, .core_priority_level, .block_active, .trap_pending, .select_fast_rc,
	.abort_access);

// [dv/tb_pitc_controller.sv]
`timescale 1ns/100ps
module tb_pitc_controller;
	logic          clk  = 1'b0;
	logic          srst = 1'b1;
	logic [44:0]   req  = '0;
	logic [44:0]   fset = '0;
	logic [44:0]   fclr = '0;
	logic [44:0]   en   = '0;
	logic [134:0]  pri  = '0;
	logic [134:0]  p;
	logic [3:0]    tin  = '0;
	logic [3:0]    tclr = '0;
	logic          mte  = 1'b0;
	logic          nd   = 1'b0;
	logic          alt  = 1'b0;
	logic          lw   = 1'b0;
	logic [2:0]    lwd  = '0;
	logic          ret  = 1'b0;
	logic          tib  = 1'b0;
	logic [13:0]   bc   = '0;
	logic          slow = 1'b0;
	logic [31:0]   seed = 32'h0000_656b;
	logic [31:0]   r;
	int            miscompares = 0;
	int            total_checks = 0;
	int            a, b, pa, pb, w, pw, l, pl;
	wire logic exception_request, block_active, select_fast_rc, abort_access, instr_boundary, exception_taken;
	wire logic [5:0]  exception_vector;
	wire logic [23:0] vector_address;
	wire logic [3:0]  core_priority_level, trap_pending;
	wire logic [44:0] irq_pending;
	always #5 clk = ~clk;
	pitc_controller u_pitc_controller (.clk, .srst, .irq_request(req), .irq_flag_set(fset), .irq_flag_clear(fclr),
		.irq_enable(en), .irq_priority(pri), .clock_failure_monitor(tin[0]), .misaligned_access(tin[1]),
		.stack_error(tin[2]), .accumulator_overflow(tin[3]), .math_trap_enable(mte), .trap_flag_clear(tclr),
		.nesting_disable(nd), .alternate_table_select(alt), .level_write(lw), .level_write_data(lwd),
		.instr_boundary, .exception_taken, .return_from_handler(ret), .timed_interrupt_block(tib),
		.block_cycles(bc), .exception_request, .exception_vector, .vector_address, .core_priority_level,
		.block_active, .irq_pending, .trap_pending, .select_fast_rc, .abort_access);
	pitc_core_model u_pitc_core_model (.clk, .exception_request, .slow, .instr_boundary, .exception_taken);
	function automatic logic [31:0] rng();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rng
	function automatic logic [23:0] ea(input logic [5:0] v);
		return (alt ? pitc_pkg::ALTERNATE_TABLE_BASE : pitc_pkg::PRIMARY_TABLE_BASE) + {17'h0_0000, v, 1'b0};
	endfunction : ea
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk
	// Wait for an offer taken by the core, then compare it
	task automatic take(input logic [5:0] v);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(exception_request === 1'b1 && exception_taken === 1'b1) && n < 60);
		if (n < 60) begin
			chk(exception_vector === v, "vector");
			chk(vector_address === ea(v), "table address");
		end else begin
			chk(1'b0, "offer timed out");
			final_report();
		end
	endtask : take
	task automatic back();
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		@(posedge clk);
	endtask : back
	task automatic lvl(input logic l, input logic [2:0] d, input logic [3:0] e);
		nd  <= l;
		lw  <= 1'b1;
		lwd <= d;
		@(posedge clk);
		lw  <= 1'b0;
		repeat (2) @(posedge clk);
		chk(core_priority_level === e, "level write");
	endtask : lvl
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		en   <= '1;
		for (int i = 0; i < 8; i++) begin
			r = rng();
			a = r % 45;
			b = (a + 1 + rng() % 44) % 45;
			pa = 1 + rng() % 7;
			pb = (i == 0) ? pa : 1 + rng() % 7;
			p = '0;
			p[3*a +: 3] = pa[2:0];
			p[3*b +: 3] = pb[2:0];
			pri <= p;
			nd <= r[29];
			alt <= r[30];
			slow <= r[31];
			@(posedge clk);
			req[a] <= 1'b1;
			fset[b] <= 1'b1;
			@(posedge clk);
			req <= '0;
			fset <= '0;
			w = (pa > pb || (pa == pb && a < b)) ? a : b;
			l = (w == a) ? b : a;
			pw = (w == a) ? pa : pb;
			pl = (w == a) ? pb : pa;
			take(6'(8 + w));
			@(posedge clk);
			chk(core_priority_level === (nd ? 4'h7 : 4'(pw)), "entry level");
			back();
			take(6'(8 + l));
			@(posedge clk);
			chk(core_priority_level === (nd ? 4'h7 : 4'(pl)), "second level");
			back();
			chk(core_priority_level === 4'h0, "level restored");
		end
		$display("end of arbitration test");
		slow <= 1'b0;
		nd <= 1'b0;
		alt <= 1'b0;
		p = '0;
		p[14:12] = 3'h5;
		pri <= p;
		en <= ~45'h0_0000_0000_0010;
		@(posedge clk);
		req <= 45'h0_0000_0000_0018;
		@(posedge clk);
		req <= '0;
		repeat (10) begin
			@(posedge clk);
			chk(exception_request === 1'b0, "refused source offered");
		end
		chk(irq_pending[4:3] === 2'b11, "pending flags");
		fclr <= 45'h0_0000_0000_0018;
		@(posedge clk);
		fclr <= '0;
		en <= '1;
		lvl(1'b0, 3'h5, 4'h5);
		lvl(1'b1, 3'h2, 4'h5);
		lvl(1'b0, 3'h0, 4'h0);
		chk(irq_pending[4:3] === 2'b00 && exception_request === 1'b0, "flags cleared");
		$display("end of refusal test");
		p = '0;
		p[2:0] = 3'h6;
		p[5:3] = 3'h7;
		pri <= p;
		@(posedge clk);
		tib <= 1'b1;
		bc <= 14'h0008;
		fset <= 45'h0_0000_0000_0001;
		@(posedge clk);
		tib <= 1'b0;
		fset <= '0;
		repeat (3) begin
			@(posedge clk);
			chk(block_active === 1'b1 && exception_request === 1'b0, "timed block");
		end
		// Level seven still gets through while the block stands
		fset <= 45'h0_0000_0000_0002;
		@(posedge clk);
		fset <= '0;
		take(6'h09);
		chk(block_active === 1'b1, "top level during block");
		back();
		take(6'h08);
		back();
		chk(block_active === 1'b0, "block ended");
		$display("end of block test");
		p[2:0] = 3'h7;
		pri <= p;
		mte <= 1'b1;
		@(posedge clk);
		tin <= 4'hF;
		fset <= 45'h0_0000_0000_0001;
		@(posedge clk);
		tin <= 4'h0;
		fset <= '0;
		for (int v = 1; v < 5; v++) begin
			take(6'(v));
			tclr <= 4'(1 << (v - 1));
			@(posedge clk);
			tclr <= 4'h0;
			chk(core_priority_level === pitc_pkg::TRAP_CPU_LEVEL, "trap level");
		end
		chk(select_fast_rc === 1'b1, "fast rc");
		repeat (4) back();
		take(6'h08);
		back();
		mte <= 1'b0;
		tin <= 4'h8;
		@(posedge clk);
		tin <= 4'h0;
		repeat (2) @(posedge clk);
		chk(trap_pending[3] === 1'b0, "math trap gated");
		$display("end of trap test");
		final_report();
	end
endmodule : tb_pitc_controller
